// ### hdl/dubp_consts.svh
// Constants for the dual-channel host bus port.
`ifndef DUBP_CONSTS_SVH
`define DUBP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Bus widths, channel count and register count
// ----------------------------------------------------------------------------
`define DUBP_ADDR_W 3
`define DUBP_DATA_W 8
`define DUBP_CHANS 2
`define DUBP_REGS 8

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define DUBP_REG_RST 8'h00
`define DUBP_STROBES_IDLE 4'hF
`define DUBP_SYNC_STAGES 2
`define DUBP_CLK_PERIOD_NS 10

// ----------------------------------------------------------------------------
// Channel encoding of the channel address bit
// ----------------------------------------------------------------------------
`define DUBP_CHAN_A 1'h0
`define DUBP_CHAN_B 1'h1

`endif

// ### hdl/dubp_pkg.sv
// Types shared by the dual-channel host bus port.
`include "dubp_consts.svh"

package dubp_pkg;

    // ------------------------------------------------------------------------
    // Basic bus types
    // ------------------------------------------------------------------------
    typedef logic [`DUBP_ADDR_W-1:0] dubp_addr_t;
    typedef logic [`DUBP_DATA_W-1:0] dubp_byte_t;

    // ------------------------------------------------------------------------
    // Access phase of the port
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        DUBP_IDLE,
        DUBP_READ,
        DUBP_WRITE
    } dubp_phase_t;

    // ------------------------------------------------------------------------
    // Whole state of the port
    // ------------------------------------------------------------------------
    typedef struct packed {
        dubp_phase_t phase;
        logic chan;
        dubp_addr_t addr;
        dubp_byte_t wbyte;
        dubp_byte_t rdata;
        logic oe_n;
        logic rd_pulse;
        logic wr_pulse;
        logic [`DUBP_CHANS-1:0][`DUBP_REGS-1:0][`DUBP_DATA_W-1:0] regs;
    } dubp_state_t;

endpackage : dubp_pkg

// ### hdl/dubp_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps

module dubp_sync #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } dubp_sync_st_t;

    dubp_sync_st_t sync_ff;
    dubp_sync_st_t nxt_sync;

    // The first stage feeds only the second stage.
    always_comb begin
        nxt_sync.meta = async_in;
        nxt_sync.stable = sync_ff.meta;
    end

    // Both stages return to the idle levels of their pins, so no false access follows reset.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync_ff.meta <= RST_VAL;
            sync_ff.stable <= RST_VAL;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff.stable;

endmodule : dubp_sync

// ### hdl/dubp_host_port.sv
// Host parallel bus port of a dual-channel UART with per-channel registers.
//
// Summary of operation
// (R1) A high bus-style pin selects strobe style, a low one selects direction-line style.
// (R2) The three address bits pick one of eight registers of the addressed channel.
// (R3) Data moves on an 8-bit two-way bus, driven by the host on writes, by the port on reads.
// (R4) In strobe style a falling read strobe starts a read and the port drives the byte out.
// (R5) In strobe style a falling write strobe starts a write, committed when the strobe rises.
// (R6) In strobe style the host selects channel A or B with its own active-low chip select.
// (R7) In direction-line style the channel A select is the only chip select of the device.
// (R8) In direction-line style the channel B select acts as channel address, 0 for A, 1 for B.
// (R9) In direction-line style the write strobe is a direction line, high read, low write.
// (R10) In direction-line style the read strobe is ignored.
// (R11) The host holds address, selects and write data stable while the access is active.
`timescale 1ns/1ps
`include "dubp_consts.svh"

module dubp_host_port (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic bus_style,
    input wire dubp_pkg::dubp_addr_t addr,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    input wire dubp_pkg::dubp_byte_t data_in,
    output dubp_pkg::dubp_byte_t data_out,
    output logic data_oe_n,
    output logic wr_pulse,
    output logic wr_chan,
    output dubp_pkg::dubp_addr_t wr_addr,
    output dubp_pkg::dubp_byte_t wr_data,
    output logic rd_pulse,
    output logic rd_chan,
    output dubp_pkg::dubp_addr_t rd_addr
);

    import dubp_pkg::*;

    localparam int PIN_W = 1 + `DUBP_ADDR_W + `DUBP_DATA_W + 4;

    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    logic [PIN_W-1:0] pins_s;
    logic style_s;
    dubp_addr_t addr_s;
    dubp_byte_t data_s;
    logic rd_n_s;
    logic wr_n_s;
    logic csa_n_s;
    logic csb_n_s;

    // Every pin passes two flip-flops before any logic reads it; strobes and selects reset high.
    dubp_sync #(
        .WIDTH(PIN_W),
        .RST_VAL({1'b1, {`DUBP_ADDR_W{1'b0}}, {`DUBP_DATA_W{1'b0}}, `DUBP_STROBES_IDLE})
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in({bus_style, addr, data_in, read_strobe_n, write_strobe_n,
                   chan_a_select_n, chan_b_select_n}),
        .sync_out(pins_s)
    );

    assign {style_s, addr_s, data_s, rd_n_s, wr_n_s, csa_n_s, csb_n_s} = pins_s;

    // ------------------------------------------------------------------------
    // Access decoding
    // ------------------------------------------------------------------------
    logic rd_act;
    logic wr_act;
    logic chan_c;

    // Works out the requested access and channel for the current bus style.
    always_comb begin
        if (style_s) begin // R1
            rd_act = !rd_n_s && (!csa_n_s || !csb_n_s); // R4
            wr_act = !wr_n_s && (!csa_n_s || !csb_n_s); // R5
            chan_c = csa_n_s ? `DUBP_CHAN_B : `DUBP_CHAN_A; // R6
        end else begin
            rd_act = !csa_n_s && wr_n_s; // R7 R9 R10
            wr_act = !csa_n_s && !wr_n_s; // R7 R9
            chan_c = csb_n_s; // R8
        end
    end

    // Picks one byte of the register file by channel and register index.
    function automatic dubp_byte_t dubp_pick(
        input logic [`DUBP_CHANS-1:0][`DUBP_REGS-1:0][`DUBP_DATA_W-1:0] regs,
        input logic chan,
        input dubp_addr_t idx
    );
        dubp_pick = regs[chan][idx];
    endfunction : dubp_pick

    // ------------------------------------------------------------------------
    // Port state machine
    // ------------------------------------------------------------------------
    dubp_state_t state_ff;
    dubp_state_t nxt_state;
    dubp_byte_t rd_pick;

    assign rd_pick = dubp_pick(state_ff.regs, chan_c, addr_s);

    // Starts reads on the active edge, tracks writes and commits them on release.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rd_pulse = 1'b0;
        nxt_state.wr_pulse = 1'b0;
        case (state_ff.phase)
            DUBP_IDLE: begin
                if (rd_act) begin
                    nxt_state.phase = DUBP_READ;
                    nxt_state.chan = chan_c;
                    nxt_state.addr = addr_s; // R2
                    nxt_state.rdata = rd_pick; // R4
                    nxt_state.oe_n = 1'b0; // R3
                    nxt_state.rd_pulse = 1'b1;
                end else if (wr_act) begin
                    nxt_state.phase = DUBP_WRITE;
                    nxt_state.chan = chan_c;
                    nxt_state.addr = addr_s;
                    nxt_state.wbyte = data_s;
                end
            end
            DUBP_READ: begin
                if (!rd_act) begin
                    nxt_state.phase = DUBP_IDLE;
                    nxt_state.oe_n = 1'b1; // R3
                end
            end
            DUBP_WRITE: begin
                if (wr_act) begin
                    // Keeps the last values seen while the strobe is still low.
                    nxt_state.chan = chan_c;
                    nxt_state.addr = addr_s;
                    nxt_state.wbyte = data_s;
                end else begin
                    nxt_state.phase = DUBP_IDLE;
                    nxt_state.regs[state_ff.chan][state_ff.addr] = state_ff.wbyte; // R5
                    nxt_state.wr_pulse = 1'b1;
                end
            end
            default: begin
                nxt_state.phase = DUBP_IDLE;
                nxt_state.oe_n = 1'b1;
            end
        endcase
    end

    // Registers the whole port state; registers clear to their reset value.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_ff.phase <= DUBP_IDLE;
            state_ff.chan <= `DUBP_CHAN_A;
            state_ff.addr <= '0;
            state_ff.wbyte <= '0;
            state_ff.rdata <= '0;
            state_ff.oe_n <= 1'b1;
            state_ff.rd_pulse <= 1'b0;
            state_ff.wr_pulse <= 1'b0;
            state_ff.regs <= {(`DUBP_CHANS * `DUBP_REGS){`DUBP_REG_RST}};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // All outputs come straight from the state register.
    assign data_out = state_ff.rdata;
    assign data_oe_n = state_ff.oe_n;
    assign wr_pulse = state_ff.wr_pulse;
    assign wr_chan = state_ff.chan;
    assign wr_addr = state_ff.addr;
    assign wr_data = state_ff.wbyte;
    assign rd_pulse = state_ff.rd_pulse;
    assign rd_chan = state_ff.chan;
    assign rd_addr = state_ff.addr;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking dubp_cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // A strobe-style read request drives the bus on the next edge.
    AST_STROBE_READ_DRIVE: assert property ( // R1
        style_s && rd_act && state_ff.phase == DUBP_IDLE |=> !data_oe_n && rd_pulse)
        else $error("Strobe read did not drive the bus.");

    // The driven byte is the register picked by channel and address.
    AST_READ_DATA: assert property ( // R2
        rd_act && state_ff.phase == DUBP_IDLE |=> data_out == $past(rd_pick))
        else $error("Read byte does not match the addressed register.");

    // The bus is never driven during a write phase.
    AST_NO_DRIVE_ON_WRITE: assert property ( // R3
        state_ff.phase == DUBP_WRITE |-> data_oe_n)
        else $error("Bus driven during a write.");

    // The bus stays driven while the read strobe stays active.
    AST_READ_HOLD: assert property ( // R4
        style_s && !data_oe_n && rd_act ##1 rd_act |-> !data_oe_n)
        else $error("Bus released during an active read.");

    // Releasing a write stores the byte and pulses the write output.
    AST_WRITE_COMMIT: assert property ( // R5
        state_ff.phase == DUBP_WRITE && !wr_act |=>
            wr_pulse && dubp_pick(state_ff.regs, wr_chan, wr_addr) == wr_data)
        else $error("Write was not committed on strobe release.");

    // In direction-line style a deasserted channel A select blocks all access.
    AST_DIR_CS: assert property ( // R7
        !style_s && csa_n_s |-> !rd_act && !wr_act)
        else $error("Access decoded without chip select.");

    // In direction-line style the channel follows the channel B select level.
    AST_DIR_CHAN: assert property ( // R8
        !style_s && rd_act && state_ff.phase == DUBP_IDLE |=> rd_chan == $past(csb_n_s))
        else $error("Wrong channel in direction-line mode.");

    // In direction-line style the write strobe sets the direction.
    AST_DIR_RW: assert property ( // R9
        !style_s && !csa_n_s |-> (rd_act == wr_n_s) && (wr_act == !wr_n_s))
        else $error("Direction line decoded wrongly.");

    // In direction-line style the read strobe has no effect.
    AST_DIR_IGNORE_RD: assert property ( // R10
        !style_s && !rd_n_s && (csa_n_s || !wr_n_s) |-> !rd_act)
        else $error("Read strobe acted in direction-line mode.");

endmodule : dubp_host_port

// ### tb/dubp_host_model.sv
// Host processor model that drives the parallel bus pins of the port.
`timescale 1ns/1ps

module dubp_host_model (
    input wire logic clk_sys,
    input wire dubp_pkg::dubp_byte_t data_out,
    input wire logic data_oe_n,
    output logic bus_style,
    output dubp_pkg::dubp_addr_t addr,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic chan_a_select_n,
    output logic chan_b_select_n,
    output dubp_pkg::dubp_byte_t data_in
);
    import dubp_pkg::*;
    logic host_drv;
    dubp_byte_t host_byte;
    dubp_byte_t bus_last;

    // Resolves the shared bus; an undriven bus shows the inverse of its last level.
    assign data_in = !data_oe_n ? data_out : (host_drv ? host_byte : ~bus_last);
    always @(posedge clk_sys) if (!data_oe_n || host_drv) bus_last <= data_in;

    // Pins rest idle from time zero.
    initial begin
        {bus_style, read_strobe_n, write_strobe_n} = 3'h7;
        {chan_a_select_n, chan_b_select_n, host_drv} = 3'h6;
        addr = 3'h0;
        host_byte = 8'h00;
        bus_last = 8'h5A;
    end

    // One whole access: settle the style, assert, hold, sample, release, idle.
    task automatic access(input logic style, input logic wr, input logic sel,
        input logic ch, input dubp_addr_t idx, input dubp_byte_t wb, output dubp_byte_t rb);
        @(negedge clk_sys);
        bus_style = style;
        repeat (3) @(negedge clk_sys);
        addr = idx;
        host_byte = wb;
        host_drv = wr;
        if (style) begin
            chan_a_select_n = !(sel && !ch);
            chan_b_select_n = !(sel && ch);
            read_strobe_n = wr;
            write_strobe_n = !wr;
        end else begin
            chan_a_select_n = !sel;
            chan_b_select_n = ch;
            write_strobe_n = !wr;
            read_strobe_n = 1'b0;
        end
        repeat (6) @(negedge clk_sys);
        rb = data_in;
        {read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n} = 4'hF;
        host_drv = 1'b0;
        repeat (5) @(negedge clk_sys);
    endtask : access
endmodule : dubp_host_model

// ### tb/dubp_host_port_tb_top.sv
// Self-checking testbench of the host bus port.
`timescale 1ns/1ps

module dubp_host_port_tb_top;
    import dubp_pkg::*;
    typedef struct packed {
        logic style;
        logic wr;
        logic ch;
        dubp_addr_t idx;
        dubp_byte_t wb;
    } dubp_row_t;
    localparam dubp_row_t ROWS [12] = '{
        '{1'h1, 1'h1, 1'h0, 3'h0, 8'hA5}, '{1'h1, 1'h1, 1'h1, 3'h7, 8'h3C},
        '{1'h0, 1'h1, 1'h0, 3'h3, 8'hC6}, '{1'h0, 1'h1, 1'h1, 3'h5, 8'h81},
        '{1'h0, 1'h0, 1'h0, 3'h0, 8'h00}, '{1'h0, 1'h0, 1'h1, 3'h7, 8'h00},
        '{1'h1, 1'h0, 1'h0, 3'h3, 8'h00}, '{1'h1, 1'h0, 1'h1, 3'h5, 8'h00},
        '{1'h1, 1'h0, 1'h1, 3'h0, 8'h00}, '{1'h0, 1'h0, 1'h0, 3'h5, 8'h00},
        '{1'h0, 1'h1, 1'h1, 3'h0, 8'hFF}, '{1'h1, 1'h0, 1'h1, 3'h0, 8'h00}};
    logic clk_sys, nrst, bus_style, read_strobe_n, write_strobe_n;
    logic chan_a_select_n, chan_b_select_n, data_oe_n, wr_pulse, wr_chan, rd_pulse, rd_chan;
    logic lw_chan, lr_chan;
    dubp_addr_t addr, wr_addr, rd_addr, lw_addr, lr_addr;
    dubp_byte_t data_in, data_out, wr_data, lw_data;
    dubp_byte_t exp_mem [2][8];
    int errors, checks, cycles, wr_seen, rd_seen;

    dubp_host_port u_dubp_host_port (.clk_sys(clk_sys), .nrst(nrst), .bus_style(bus_style),
        .addr(addr), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .wr_pulse(wr_pulse),
        .wr_chan(wr_chan), .wr_addr(wr_addr), .wr_data(wr_data), .rd_pulse(rd_pulse),
        .rd_chan(rd_chan), .rd_addr(rd_addr));
    dubp_host_model u_dubp_host_model (.clk_sys(clk_sys), .data_out(data_out),
        .data_oe_n(data_oe_n), .bus_style(bus_style), .addr(addr),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n),
        .data_in(data_in));

    // Free-running system clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Counts pulses, keeps the last targets, and cuts a hang short.
    always @(negedge clk_sys) begin
        cycles++;
        if (wr_pulse === 1'b1) begin
            wr_seen++;
            {lw_chan, lw_addr, lw_data} = {wr_chan, wr_addr, wr_data};
        end
        if (rd_pulse === 1'b1) begin
            rd_seen++;
            {lr_chan, lr_addr} = {rd_chan, rd_addr};
        end
        if (cycles == 2000) begin
            errors++;
            $display("BAD %0t run timed out", $time);
            complete_run();
        end
    end

    // Compares one byte-wide result.
    task automatic chk_byte(input dubp_byte_t got, input dubp_byte_t exp, input string msg);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk_byte

    // Compares one pulse count.
    task automatic chk_cnt(input int got, input int exp, input string msg);
        checks++;
        if (got != exp) begin
            errors++;
            $display("BAD %0t %s got %0d expected %0d", $time, msg, got, exp);
        end
    endtask : chk_cnt

    // Runs one access and checks pulses, targets and read data.
    task automatic do_access(input logic style, input logic wr, input logic sel,
        input logic ch, input dubp_addr_t idx, input dubp_byte_t wb);
        int w0;
        int r0;
        dubp_byte_t rb;
        w0 = wr_seen;
        r0 = rd_seen;
        u_dubp_host_model.access(style, wr, sel, ch, idx, wb, rb);
        chk_byte({7'h00, data_oe_n}, 8'h01, "bus released");
        chk_cnt(wr_seen - w0, (sel && wr) ? 1 : 0, "write pulses");
        chk_cnt(rd_seen - r0, (sel && !wr) ? 1 : 0, "read pulses");
        if (sel && wr) begin
            exp_mem[ch][idx] = wb;
            chk_byte({4'h0, lw_chan, lw_addr}, {4'h0, ch, idx}, "write target");
            chk_byte(lw_data, wb, "write data");
        end
        if (sel && !wr) begin
            chk_byte({4'h0, lr_chan, lr_addr}, {4'h0, ch, idx}, "read target");
            chk_byte(rb, exp_mem[ch][idx], "read data");
        end
    endtask : do_access

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    // Main sequence: reset, table of accesses, then the awkward cases.
    initial begin
        {errors, checks, cycles, wr_seen, rd_seen} = '0;
        nrst = 1'b0;
        foreach (exp_mem[c, r]) exp_mem[c][r] = 8'h00;
        repeat (10) @(negedge clk_sys);
        chk_byte({5'h00, data_oe_n, wr_pulse, rd_pulse}, 8'h04, "reset flags");
        nrst = 1'b1;
        foreach (ROWS[i]) begin
            do_access(ROWS[i].style, ROWS[i].wr, 1'b1, ROWS[i].ch, ROWS[i].idx, ROWS[i].wb);
        end
        do_access(1'b0, 1'b1, 1'b0, 1'b0, 3'h2, 8'h77);
        do_access(1'b1, 1'b0, 1'b1, 1'b0, 3'h3, 8'h00);
        @(negedge clk_sys);
        nrst = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk_byte(data_out, 8'h00, "reset data");
        nrst = 1'b1;
        foreach (exp_mem[c, r]) exp_mem[c][r] = 8'h00;
        do_access(1'b0, 1'b0, 1'b1, 1'b1, 3'h7, 8'h00);
        complete_run();
    end
endmodule : dubp_host_port_tb_top
